// *** logic/drx_config_regs.sv ***
// Contract
// R1: Bit 7 clear: A odd, B even pixels
// R2: Bit 7 set: A left, B right half
// R3: Topology 00 dual, 01 single, 10 two
// R4: Topology resets to single channel
// R5: Channel A lane code, resets one lane
// R6: Channel B same lane code, one lane
// R7: Bit 0 chooses tolerant or strict leader
// R8: Channel A data eq: none, 1dB, 2dB
// R9: Channel B data eq, same encoding
// R10: Clock eq fields for A and B
// R11: All equalization fields reset to none
// R12: Two receivers, both links: two links
// R13: Fields read back last written value
`timescale 1ns/10ps
`default_nettype none
module drx_config_regs #(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Leader bytes, channel A low, channel B high
  input wire logic [1:0] sotValid,
  input wire logic [15:0] sotByte,
  output logic [1:0] sotAccept,
  output logic [1:0] sotReject,
  // Output link state
  input wire logic lvdsBothLinks,
  // Decoded configuration
  output logic oddEvenSplit,
  output logic leftRightSplit,
  output logic dualChannel,
  output logic singleChannel,
  output logic twoSingleChannels,
  output logic twoSingleLinks,
  output logic [3:0] chanALaneEnable,
  output logic [3:0] chanBLaneEnable,
  output logic strictStartCheck,
  output logic [1:0] chanADataEqDb,
  output logic [1:0] chanBDataEqDb,
  output logic [1:0] chanAClockEqDb,
  output logic [1:0] chanBClockEqDb
);

  if (ADDR_W < 10)
  begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end

  logic [7:0] channelSetup;
  logic [7:0] equalization;
  logic [1:0] lastReject;
  logic [7:0] status;
  logic [7:0] readMux;
  logic mapped;
  logic doneEdge;
  logic [1:0] topo;

  function automatic logic isAt(input logic [ADDR_W-1:0] a,
                                input logic [9:0] target);
    isAt = (a == ADDR_W'(target));
  endfunction

  function automatic logic [3:0] laneMask(input logic [1:0] code);
    unique case (code)
      2'h0: laneMask = 4'hf;
      2'h1: laneMask = 4'h7;
      2'h2: laneMask = 4'h3;
      2'h3: laneMask = 4'h1;
    endcase
  endfunction

  // Reserved code drives no equalization rather than a guess
  function automatic logic [1:0] eqDb(input logic [1:0] code);
    unique case (code)
      drx_pkg::EQ_NONE: eqDb = 2'h0;
      drx_pkg::EQ_1DB: eqDb = drx_pkg::DB_ONE;
      drx_pkg::EQ_RSVD: eqDb = 2'h0;
      drx_pkg::EQ_2DB: eqDb = drx_pkg::DB_TWO;
    endcase
  endfunction

  function automatic logic sotOk(input logic [7:0] leader,
                                 input logic strict);
    logic [3:0] errs;
    errs = 4'($countones(leader ^ drx_pkg::SOT_SYNC));
    sotOk = (errs == 4'h0) || (!strict && errs == 4'h1);
  endfunction

  assign topo = channelSetup[drx_pkg::TOPO_LSB +: 2];
  assign doneEdge = psel && penable && pready;
  assign mapped = isAt(paddr, drx_pkg::ADDR_SETUP) ||
                  isAt(paddr, drx_pkg::ADDR_EQ) ||
                  isAt(paddr, drx_pkg::ADDR_STATUS);
  assign status = {4'h0, lastReject,
                   |{equalization[7:6] == drx_pkg::EQ_RSVD,
                     equalization[5:4] == drx_pkg::EQ_RSVD,
                     equalization[3:2] == drx_pkg::EQ_RSVD,
                     equalization[1:0] == drx_pkg::EQ_RSVD},
                   topo == drx_pkg::TOPO_RSVD};

  always_comb
  begin
    readMux = 8'h00;
    if (isAt(paddr, drx_pkg::ADDR_SETUP))
      readMux = channelSetup;
    else if (isAt(paddr, drx_pkg::ADDR_EQ))
      readMux = equalization;
    else if (isAt(paddr, drx_pkg::ADDR_STATUS))
      readMux = status;
  end

  // One wait state keeps pready and prdata straight from flops
  always_ff @(posedge clock)
  begin
    if (srst)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, readMux}; // [R13]
      pslverr <= !mapped;
    end
    else
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Reserved codes are stored as written and flagged in status
  always_ff @(posedge clock)
  begin
    if (srst)
      channelSetup <= drx_pkg::SETUP_RESET; // [R4] [R5] [R6]
    else if (doneEdge && pwrite && pstrb[0] &&
             isAt(paddr, drx_pkg::ADDR_SETUP))
      channelSetup <= pwdata[7:0]; // [R13]
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      equalization <= drx_pkg::EQ_RESET; // [R11]
    else if (doneEdge && pwrite && pstrb[0] &&
             isAt(paddr, drx_pkg::ADDR_EQ))
      equalization <= pwdata[7:0]; // [R13]
  end

  // Reserved topology falls back to single channel
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dualChannel <= 1'b0;
      singleChannel <= 1'b1;
      twoSingleChannels <= 1'b0;
      oddEvenSplit <= 1'b0;
      leftRightSplit <= 1'b0;
      twoSingleLinks <= 1'b0;
    end
    else
    begin
      dualChannel <= topo == drx_pkg::TOPO_DUAL; // [R3]
      singleChannel <= topo == drx_pkg::TOPO_SINGLE ||
                       topo == drx_pkg::TOPO_RSVD;
      twoSingleChannels <= topo == drx_pkg::TOPO_TWO;
      oddEvenSplit <= topo == drx_pkg::TOPO_DUAL &&
                      !channelSetup[drx_pkg::PIX_BIT]; // [R1]
      leftRightSplit <= topo == drx_pkg::TOPO_DUAL &&
                        channelSetup[drx_pkg::PIX_BIT]; // [R2]
      twoSingleLinks <= topo == drx_pkg::TOPO_TWO &&
                        lvdsBothLinks; // [R12]
    end
  end

  // Channel B idles in single-channel mode
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      chanALaneEnable <= 4'h1;
      chanBLaneEnable <= 4'h0;
      strictStartCheck <= 1'b0;
    end
    else
    begin
      chanALaneEnable <=
        laneMask(channelSetup[drx_pkg::LANEA_LSB +: 2]); // [R5]
      chanBLaneEnable <= singleChannel ? 4'h0 :
        laneMask(channelSetup[drx_pkg::LANEB_LSB +: 2]); // [R6]
      strictStartCheck <= channelSetup[drx_pkg::STRICT_BIT]; // [R7]
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      chanADataEqDb <= 2'h0;
      chanBDataEqDb <= 2'h0;
      chanAClockEqDb <= 2'h0;
      chanBClockEqDb <= 2'h0;
    end
    else
    begin
      chanADataEqDb <= eqDb(equalization[drx_pkg::EQ_DA_LSB +: 2]); // [R8]
      chanBDataEqDb <= eqDb(equalization[drx_pkg::EQ_DB_LSB +: 2]); // [R9]
      chanAClockEqDb <= eqDb(equalization[drx_pkg::EQ_CA_LSB +: 2]); // [R10]
      chanBClockEqDb <= eqDb(equalization[drx_pkg::EQ_CB_LSB +: 2]); // [R10]
    end
  end

  // Uses the live bit so a rewrite applies to the next leader
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sotAccept <= 2'h0;
      sotReject <= 2'h0;
      lastReject <= 2'h0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        sotAccept[c] <= sotValid[c] && sotOk(sotByte[8*c +: 8],
          channelSetup[drx_pkg::STRICT_BIT]); // [R7]
        sotReject[c] <= sotValid[c] && !sotOk(sotByte[8*c +: 8],
          channelSetup[drx_pkg::STRICT_BIT]); // [R7]
        if (sotValid[c])
          lastReject[c] <= !sotOk(sotByte[8*c +: 8],
            channelSetup[drx_pkg::STRICT_BIT]);
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  oddEven_a: assert property ( // [R1]
    topo == drx_pkg::TOPO_DUAL && !channelSetup[drx_pkg::PIX_BIT]
    |=> oddEvenSplit && !leftRightSplit)
    else $error("odd/even split not selected");
  leftRight_a: assert property ( // [R2]
    topo == drx_pkg::TOPO_DUAL && channelSetup[drx_pkg::PIX_BIT]
    |=> leftRightSplit && !oddEvenSplit)
    else $error("left/right split not selected");
  topology_a: assert property ( // [R3]
    topo == drx_pkg::TOPO_TWO
    |=> twoSingleChannels && !dualChannel && !singleChannel)
    else $error("two-receiver topology not decoded");
  topoReset_a: assert property (disable iff (1'b0) // [R4]
    srst |=> topo == drx_pkg::TOPO_SINGLE ##1 singleChannel)
    else $error("topology reset value wrong");
  laneA_a: assert property ( // [R5]
    channelSetup[drx_pkg::LANEA_LSB +: 2] == 2'h2
    |=> chanALaneEnable == 4'h3)
    else $error("channel A two-lane mask wrong");
  laneB_a: assert property ( // [R6]
    !singleChannel && channelSetup[drx_pkg::LANEB_LSB +: 2] == 2'h0
    |=> chanBLaneEnable == 4'hf)
    else $error("channel B four-lane mask wrong");
  strictStart_a: assert property ( // [R7]
    sotValid[0] && channelSetup[drx_pkg::STRICT_BIT] &&
    $countones(sotByte[7:0] ^ drx_pkg::SOT_SYNC) == 1
    |=> sotReject[0] && !sotAccept[0])
    else $error("single-bit leader error not rejected");
  tolerantStart_a: assert property ( // [R7]
    sotValid[1] && !channelSetup[drx_pkg::STRICT_BIT] &&
    $countones(sotByte[15:8] ^ drx_pkg::SOT_SYNC) == 1
    |=> sotAccept[1] && !sotReject[1])
    else $error("single-bit leader error not tolerated");
  dataEqA_a: assert property ( // [R8]
    equalization[drx_pkg::EQ_DA_LSB +: 2] == drx_pkg::EQ_2DB
    |=> chanADataEqDb == drx_pkg::DB_TWO)
    else $error("channel A data eq wrong");
  dataEqB_a: assert property ( // [R9]
    equalization[drx_pkg::EQ_DB_LSB +: 2] == drx_pkg::EQ_1DB
    |=> chanBDataEqDb == drx_pkg::DB_ONE)
    else $error("channel B data eq wrong");
  // Held field only, so the decode has had its cycle to settle
  clockEq_a: assert property ( // [R10]
    equalization[drx_pkg::EQ_CB_LSB +: 2] == drx_pkg::EQ_2DB &&
    $stable(equalization)
    |=> chanBClockEqDb == drx_pkg::DB_TWO && $stable(chanBClockEqDb))
    else $error("channel B clock eq wrong");
  eqReset_a: assert property (disable iff (1'b0) // [R11]
    srst |=> equalization == drx_pkg::EQ_RESET)
    else $error("equalization reset value wrong");
  twoLinks_a: assert property ( // [R12]
    topo == drx_pkg::TOPO_TWO && lvdsBothLinks |=> twoSingleLinks)
    else $error("two single links not selected");
  writeBack_a: assert property ( // [R13]
    doneEdge && pwrite && pstrb[0] &&
    isAt(paddr, drx_pkg::ADDR_SETUP)
    |=> channelSetup == $past(pwdata[7:0]))
    else $error("setup write not stored");
  readBack_a: assert property ( // [R13]
    psel && penable && !pready && !pwrite &&
    isAt(paddr, drx_pkg::ADDR_EQ)
    |=> pready && prdata == {24'h00_0000, equalization})
    else $error("equalization read data wrong");
  unmapped_a: assert property (
    psel && penable && !pready && !mapped |=> pready && pslverr)
    else $error("unmapped access not errored");

  writeSetup_c: cover property (
    doneEdge && pwrite && isAt(paddr, drx_pkg::ADDR_SETUP));
  readEq_c: cover property (
    doneEdge && !pwrite && isAt(paddr, drx_pkg::ADDR_EQ));
  sotReject_c: cover property (sotReject[0] ##2 sotAccept[0]);

endmodule
`default_nettype wire

// *** include/drx_pkg.sv ***
`default_nettype none
package drx_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SETUP = 8'h10;
  localparam logic [7:0] IDX_EQ = 8'h11;
  localparam logic [7:0] IDX_STATUS = 8'h3f;
  localparam logic [9:0] ADDR_SETUP = {IDX_SETUP, 2'b00};
  localparam logic [9:0] ADDR_EQ = {IDX_EQ, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  // Channel setup fields
  localparam int PIX_BIT = 7;
  localparam int TOPO_LSB = 5;
  localparam int LANEA_LSB = 3;
  localparam int LANEB_LSB = 1;
  localparam int STRICT_BIT = 0;
  // Equalization fields
  localparam int EQ_DA_LSB = 6;
  localparam int EQ_DB_LSB = 4;
  localparam int EQ_CA_LSB = 2;
  localparam int EQ_CB_LSB = 0;
  // Values after reset
  localparam logic [7:0] SETUP_RESET = 8'h3e;
  localparam logic [7:0] EQ_RESET = 8'h00;
  // Topology codes
  localparam logic [1:0] TOPO_DUAL = 2'h0;
  localparam logic [1:0] TOPO_SINGLE = 2'h1;
  localparam logic [1:0] TOPO_TWO = 2'h2;
  localparam logic [1:0] TOPO_RSVD = 2'h3;
  // Equalization codes and decoded strengths in dB
  localparam logic [1:0] EQ_NONE = 2'h0;
  localparam logic [1:0] EQ_1DB = 2'h1;
  localparam logic [1:0] EQ_RSVD = 2'h2;
  localparam logic [1:0] EQ_2DB = 2'h3;
  localparam logic [1:0] DB_ONE = 2'h1;
  localparam logic [1:0] DB_TWO = 2'h2;
  // Start-of-transmission leader pattern
  localparam logic [7:0] SOT_SYNC = 8'hb8;
endpackage
`default_nettype wire

// *** tb/test_drx_config_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_drx_config_regs;
  logic clock, srst, psel, penable, pwrite, pready, pslverr;
  logic lvdsBothLinks, oddEvenSplit, leftRightSplit, dualChannel;
  logic singleChannel, twoSingleChannels, twoSingleLinks, strictStartCheck;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, chanALaneEnable, chanBLaneEnable;
  logic [1:0] sotValid, sotAccept, sotReject;
  logic [1:0] chanADataEqDb, chanBDataEqDb, chanAClockEqDb, chanBClockEqDb;
  logic [15:0] sotByte;
  logic [7:0] sreg, ereg;
  int bad_count, n_checks;

  drx_config_regs dut (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sotValid(sotValid), .sotByte(sotByte), .sotAccept(sotAccept),
    .sotReject(sotReject), .lvdsBothLinks(lvdsBothLinks),
    .oddEvenSplit(oddEvenSplit), .leftRightSplit(leftRightSplit),
    .dualChannel(dualChannel), .singleChannel(singleChannel),
    .twoSingleChannels(twoSingleChannels), .twoSingleLinks(twoSingleLinks),
    .chanALaneEnable(chanALaneEnable), .chanBLaneEnable(chanBLaneEnable),
    .strictStartCheck(strictStartCheck), .chanADataEqDb(chanADataEqDb),
    .chanBDataEqDb(chanBDataEqDb), .chanAClockEqDb(chanAClockEqDb),
    .chanBClockEqDb(chanBClockEqDb)
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic close_out;
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request stands until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1);
    chk("wait", 32'h2, n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [9:0] a, input logic [31:0] e,
                     input logic er, input string nm);
    logic [31:0] rd;
    logic x;
    apb(1'b0, a, $urandom, 4'hf, rd, x);
    chk(nm, e, rd);
    chk("pslverr", {31'h0, er}, {31'h0, x});
  endtask

  task automatic wrc(input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic er);
    logic [31:0] rd;
    logic x;
    apb(1'b1, a, d, s, rd, x);
    chk("pslverr", {31'h0, er}, {31'h0, x});
  endtask

  // Status: any reserved eq code, reserved topology; no leaders yet
  function automatic logic [31:0] sexp(input logic [7:0] s,
                                       input logic [7:0] q);
    logic r;
    r = 1'b0;
    for (int f = 0; f < 4; f++)
      r = r | (q[2*f +: 2] == 2'h2);
    return {30'h0, r, s[6:5] == 2'h3};
  endfunction

  function automatic logic [3:0] lane(input logic [1:0] c);
    return 4'hf >> c;
  endfunction

  function automatic logic [1:0] eqd(input logic [1:0] c);
    return c == 2'h3 ? 2'h2 : {1'b0, c == 2'h1};
  endfunction

  function automatic logic [22:0] dexp(input logic [7:0] s,
                                       input logic [7:0] q, input logic b);
    logic [1:0] t;
    t = s[6:5];
    return {t == 2'h0 && !s[7], t == 2'h0 && s[7], t == 2'h0, t[0],
            t == 2'h2, t == 2'h2 && b, lane(s[4:3]),
            t[0] ? 4'h0 : lane(s[2:1]), s[0], eqd(q[7:6]), eqd(q[5:4]),
            eqd(q[3:2]), eqd(q[1:0])};
  endfunction

  // Decoded outputs lag the register by a cycle, chanBLaneEnable by two after a topology change
  task automatic dchk;
    repeat (3) @(posedge clock);
    chk("decode", {9'h0, dexp(sreg, ereg, lvdsBothLinks)},
        {9'h0, oddEvenSplit, leftRightSplit, dualChannel, singleChannel,
         twoSingleChannels, twoSingleLinks, chanALaneEnable,
         chanBLaneEnable, strictStartCheck, chanADataEqDb, chanBDataEqDb,
         chanAClockEqDb, chanBClockEqDb});
  endtask

  task automatic sot(input logic ch, input logic [7:0] b);
    int k;
    logic ok;
    k = $countones(b ^ drx_pkg::SOT_SYNC);
    ok = k == 0 || (k == 1 && !sreg[0]);
    @(posedge clock);
    sotValid[ch] <= 1'b1;
    sotByte <= {b, b};
    @(posedge clock);
    sotValid <= 2'b00;
    @(negedge clock);
    chk("leader", {28'h0, !ok && ch, !ok && !ch, ok && ch, ok && !ch},
        {28'h0, sotReject, sotAccept});
  endtask

  initial
  begin
    #100000;
    bad_count++;
    close_out();
  end

  initial
  begin
    logic [31:0] d;
    logic [7:0] e;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {sotValid, sotByte, lvdsBothLinks} = '0;
    srst = 1'b1;
    bad_count = 0;
    n_checks = 0;
    sreg = {1'b0, 2'h1, 2'h3, 2'h3, 1'b0};
    ereg = 8'h00;
    void'($urandom(53));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    dchk();
    rdc(drx_pkg::ADDR_SETUP, {24'h0, sreg}, 1'b0, "setup");
    rdc(drx_pkg::ADDR_EQ, 32'h0, 1'b0, "eq");
    // Every setup value, reserved topology included
    for (int i = 0; i < 256; i++)
    begin
      d = $urandom;
      wrc(drx_pkg::ADDR_SETUP, {d[31:8], i[7:0]}, {d[11:9], 1'b1}, 1'b0);
      sreg = i[7:0];
      d = $urandom;
      wrc(drx_pkg::ADDR_EQ, d, {d[11:9], d[8]}, 1'b0);
      if (d[8])
        ereg = d[7:0];
      lvdsBothLinks <= d[12];
      rdc(drx_pkg::ADDR_SETUP, {24'h0, sreg}, 1'b0, "setup");
      rdc(drx_pkg::ADDR_EQ, {24'h0, ereg}, 1'b0, "eq");
      dchk();
    end
    rdc(drx_pkg::ADDR_STATUS, sexp(sreg, ereg), 1'b0, "status");
    // Reset again with non-reset contents in both registers
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    sreg = drx_pkg::SETUP_RESET;
    ereg = drx_pkg::EQ_RESET;
    dchk();
    rdc(drx_pkg::ADDR_SETUP, {24'h0, sreg}, 1'b0, "setup");
    rdc(drx_pkg::ADDR_EQ, {24'h0, ereg}, 1'b0, "eq");
    rdc(10'h080, 32'h0, 1'b1, "unmapped");
    wrc(10'h080, $urandom, 4'hf, 1'b1);
    rdc(drx_pkg::ADDR_SETUP, {24'h0, sreg}, 1'b0, "setup");
    // Zero, one and two flipped leader bits, tolerant then strict
    for (int m = 0; m < 2; m++)
    begin
      sreg = {sreg[7:1], m[0]};
      wrc(drx_pkg::ADDR_SETUP, {24'h0, sreg}, 4'h1, 1'b0);
      for (int i = 0; i < 48; i++)
      begin
        d = $urandom;
        e = (i % 3 == 0) ? 8'h0 : (i % 3 == 1) ? 8'h1 << d[2:0] :
            8'h3 << d[2:0];
        sot(d[3], drx_pkg::SOT_SYNC ^ e);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
